// ===== design/sfcr_pkg.sv
// Notes on behaviour
// - read-only 8-bit checksum, resets to one
// - checksum is an 8-bit CRC
// - live 30-bit timeout value, top bits zero
// - result port pops next word, empty reads zero
// - command write while full is dropped
// - key value unlocks the sleep request register
// - any other key relocks; key resets locked
// - locked sleep request register ignores writes
// - set request bit sleeps at sequence end
// - descriptors: length 26:16, origin 10:0
// - 11-bit store location for next command
// - result behaviour 10 queue, 11 stream
// - result size codes 1..3 give 2/4/6 kB
// - command size 1..3; behaviour 01 memory mode
// - queue disabled: held empty, transfers blocked
// - stop_on_underflow halts on empty fetch
package sfcr_pkg;
   // byte offsets of the register bank
   localparam logic [15:0] OFS_SEQ_CTRL = 16'h2000;
   localparam logic [15:0] OFS_QUEUE_CTRL = 16'h2008;
   localparam logic [15:0] OFS_CHECKSUM = 16'h2060;
   localparam logic [15:0] OFS_TIMEOUT = 16'h2068;
   localparam logic [15:0] OFS_RESULT_PORT = 16'h206C;
   localparam logic [15:0] OFS_CMD_PORT = 16'h2070;
   localparam logic [15:0] OFS_SLEEP_KEY = 16'h2118;
   localparam logic [15:0] OFS_SLEEP_REQ = 16'h211C;
   localparam logic [15:0] OFS_SEQ0_DESC = 16'h21CC;
   localparam logic [15:0] OFS_SEQ2_DESC = 16'h21D0;
   localparam logic [15:0] OFS_STORE_PTR = 16'h21D4;
   localparam logic [15:0] OFS_MEM_CFG = 16'h21D8;
   localparam logic [15:0] OFS_STATUS = 16'h2204;
   // field positions
   localparam int SEQ_EN_BIT = 0;
   localparam int STOP_UNDERFLOW_BIT = 1;
   localparam int QUEUE_EN_BIT = 11;
   localparam int SLEEP_BIT = 0;
   localparam int LEN_LSB = 16;
   // reset values and constants
   localparam logic [7:0] CHECKSUM_RESET = 8'h01;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [19:0] SLEEP_KEY_VALUE = 20'hA47E5;
   localparam logic [11:0] MEM_CFG_RESET = 12'h410;
   localparam logic STOP_UNDERFLOW_RESET = 1'b1;
   localparam logic [2:0] BEHAV_MEMORY = 3'h1;
   localparam logic [2:0] BEHAV_QUEUE = 3'h2;
   localparam logic [2:0] BEHAV_STREAM = 3'h3;
   localparam logic [2:0] SIZE_2KB = 3'h1;
   localparam logic [2:0] SIZE_4KB = 3'h2;
   localparam logic [2:0] SIZE_6KB = 3'h3;

   // sequencer run state, one-hot
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_RUN = 4'h2,
      SEQ_HALTED = 4'h4,
      SEQ_ASLEEP = 4'h8
   } sfcr_state_e;

   // one sequence descriptor
   typedef struct packed {
      logic [10:0] length;
      logic [10:0] origin;
   } sfcr_desc_s;

   // memory partition fields, msb first as in the register
   typedef struct packed {
      logic [2:0] result_memory_behaviour;
      logic [2:0] result_memory_size;
      logic [2:0] command_memory_behaviour;
      logic [2:0] command_memory_size;
   } sfcr_memcfg_s;

   // command store write toward the sequencer SRAM
   typedef struct packed {
      logic we;
      logic [10:0] store_location;
      logic [31:0] word;
   } sfcr_store_s;
endpackage : sfcr_pkg

// ===== design/sfcr_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sfcr_top #(
   parameter int CMD_DEPTH = 16,
   parameter int RES_DEPTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic res_valid,
   input wire logic [31:0] res_word,
   output logic res_ready,
   output logic cmd_valid,
   output logic [31:0] cmd_word,
   input wire logic cmd_ready,
   input wire logic seq_fetch,
   input wire logic exec_valid,
   input wire logic [31:0] exec_word,
   input wire logic seq_end,
   input wire logic [29:0] timeout_value,
   output sfcr_pkg::sfcr_state_e seq_state,
   output logic sleep_enter,
   output sfcr_pkg::sfcr_desc_s seq0_desc,
   output sfcr_pkg::sfcr_desc_s seq2_desc,
   output sfcr_pkg::sfcr_memcfg_s mem_cfg,
   output sfcr_pkg::sfcr_store_s cmd_store
);
   localparam int CAW = $clog2(CMD_DEPTH);
   localparam int RAW = $clog2(RES_DEPTH);

   // crc-8 over one 32-bit command, msb first
   function automatic logic [7:0] crc8_word(input logic [7:0] crc,
                                            input logic [31:0] w);
      logic [7:0] c;
      c = crc;
      for (int i = 31; i >= 0; i--) begin
         if (c[7] ^ w[i]) begin
            c = {c[6:0], 1'b0} ^ sfcr_pkg::CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : crc8_word

   // apb phase decode
   logic setup_phase;
   logic done;
   logic wr_done;
   logic rd_done;
   assign setup_phase = psel & ~penable;
   assign done = psel & penable & pready;
   assign wr_done = done & pwrite;
   assign rd_done = done & ~pwrite;

   // control registers
   logic seq_en_q;
   logic stop_uf_q;
   logic queue_en_q;
   logic [7:0] crc_q;
   logic [19:0] key_q;
   logic sleep_req_q;
   // next free command store location, kept apart from the output copy
   logic [10:0] store_ptr_q;
   logic unlocked;
   assign unlocked = (key_q == sfcr_pkg::SLEEP_KEY_VALUE);

   // command queue storage
   logic [31:0] cmem [CMD_DEPTH];
   logic [CAW-1:0] cwr_q;
   logic [CAW-1:0] crd_q;
   logic [CAW:0] ccnt_q;
   logic cfull;
   logic cpush;
   logic cpop;
   logic mem_mode;
   assign cfull = (ccnt_q == (CAW+1)'(CMD_DEPTH));
   assign mem_mode = (mem_cfg.command_memory_behaviour ==
                      sfcr_pkg::BEHAV_MEMORY);
   assign cpush = wr_done & (paddr == sfcr_pkg::OFS_CMD_PORT) &
                  ~mem_mode & ~cfull;
   assign cpop = (ccnt_q != '0) & (~cmd_valid | cmd_ready);

   // result queue storage and its two-entry input buffer
   logic [31:0] rmem [RES_DEPTH];
   logic [RAW-1:0] rwr_q;
   logic [RAW-1:0] rrd_q;
   logic [RAW:0] rcnt_q;
   logic [31:0] buf_q [2];
   logic [1:0] bcnt_q;
   logic [1:0] bcnt_d;
   logic bpush;
   logic bpop;
   logic rpop;
   logic rempty;
   assign rempty = (rcnt_q == '0);
   assign bpush = res_valid & res_ready;
   assign bpop = (bcnt_q != 2'h0) & queue_en_q &
                 (rcnt_q != (RAW+1)'(RES_DEPTH));
   assign rpop = rd_done & (paddr == sfcr_pkg::OFS_RESULT_PORT) &
                 ~rempty & queue_en_q;

   // read mux and address check
   logic [31:0] rd_d;
   logic err_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      case (paddr)
         sfcr_pkg::OFS_SEQ_CTRL: begin
            rd_d[sfcr_pkg::SEQ_EN_BIT] = seq_en_q;
            rd_d[sfcr_pkg::STOP_UNDERFLOW_BIT] = stop_uf_q;
         end
         sfcr_pkg::OFS_QUEUE_CTRL: begin
            rd_d[sfcr_pkg::QUEUE_EN_BIT] = queue_en_q;
         end
         sfcr_pkg::OFS_CHECKSUM: rd_d[7:0] = crc_q;
         sfcr_pkg::OFS_TIMEOUT: rd_d[29:0] = timeout_value;
         sfcr_pkg::OFS_RESULT_PORT: begin
            if (!rempty && queue_en_q) begin
               rd_d = rmem[rrd_q];
            end
         end
         sfcr_pkg::OFS_CMD_PORT: rd_d = 32'h0000_0000;
         sfcr_pkg::OFS_SLEEP_KEY: rd_d[19:0] = key_q;
         sfcr_pkg::OFS_SLEEP_REQ: rd_d[sfcr_pkg::SLEEP_BIT] = sleep_req_q;
         sfcr_pkg::OFS_SEQ0_DESC: begin
            rd_d[26:16] = seq0_desc.length;
            rd_d[10:0] = seq0_desc.origin;
         end
         sfcr_pkg::OFS_SEQ2_DESC: begin
            rd_d[26:16] = seq2_desc.length;
            rd_d[10:0] = seq2_desc.origin;
         end
         sfcr_pkg::OFS_STORE_PTR: rd_d[10:0] = store_ptr_q;
         sfcr_pkg::OFS_MEM_CFG: rd_d[11:0] = mem_cfg;
         sfcr_pkg::OFS_STATUS: begin
            rd_d[3:0] = seq_state;
            rd_d[4] = cfull;
            rd_d[5] = (ccnt_q == '0) & ~cmd_valid;
            rd_d[6] = rempty;
            rd_d[7] = unlocked;
            rd_d[16 +: RAW+1] = rcnt_q;
         end
         default: err_d = 1'b1;
      endcase
   end

   // apb answer one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & err_d;
         if (setup_phase && !pwrite) begin
            prdata <= rd_d;
         end
      end
   end

   // sequencer and queue control bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_en_q <= 1'b0;
         stop_uf_q <= sfcr_pkg::STOP_UNDERFLOW_RESET;
         queue_en_q <= 1'b0;
      end else if (wr_done && paddr == sfcr_pkg::OFS_SEQ_CTRL) begin
         seq_en_q <= pwdata[sfcr_pkg::SEQ_EN_BIT];
         stop_uf_q <= pwdata[sfcr_pkg::STOP_UNDERFLOW_BIT];
      end else if (wr_done && paddr == sfcr_pkg::OFS_QUEUE_CTRL) begin
         queue_en_q <= pwdata[sfcr_pkg::QUEUE_EN_BIT];
      end
   end

   // sleep key and protected sleep request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= 20'h0_0000;
         sleep_req_q <= 1'b0;
      end else begin
         if (wr_done && paddr == sfcr_pkg::OFS_SLEEP_KEY) begin
            key_q <= pwdata[19:0];
         end
         if (wr_done && paddr == sfcr_pkg::OFS_SLEEP_REQ && unlocked) begin
            sleep_req_q <= pwdata[sfcr_pkg::SLEEP_BIT];
         end
      end
   end

   // descriptors, store pointer, memory partition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq0_desc <= '0;
         seq2_desc <= '0;
         mem_cfg <= sfcr_pkg::MEM_CFG_RESET;
         cmd_store <= '0;
         store_ptr_q <= 11'h000;
      end else begin
         cmd_store.we <= 1'b0;
         if (wr_done && paddr == sfcr_pkg::OFS_SEQ0_DESC) begin
            seq0_desc <= {pwdata[26:16], pwdata[10:0]};
         end
         if (wr_done && paddr == sfcr_pkg::OFS_SEQ2_DESC) begin
            seq2_desc <= {pwdata[26:16], pwdata[10:0]};
         end
         if (wr_done && paddr == sfcr_pkg::OFS_MEM_CFG) begin
            mem_cfg <= pwdata[11:0];
         end
         if (wr_done && paddr == sfcr_pkg::OFS_STORE_PTR) begin
            store_ptr_q <= pwdata[10:0];
         end else if (wr_done && paddr == sfcr_pkg::OFS_CMD_PORT &&
                      mem_mode) begin
            cmd_store.we <= 1'b1;
            cmd_store.word <= pwdata;
            cmd_store.store_location <= store_ptr_q; // word lands here
            store_ptr_q <= store_ptr_q + 11'h001;
         end
      end
   end

   // command queue pointers and array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cwr_q <= '0;
         crd_q <= '0;
         ccnt_q <= '0;
      end else begin
         if (cpush) begin
            cwr_q <= (cwr_q == CAW'(CMD_DEPTH - 1)) ? '0 : cwr_q + 1'b1;
         end
         if (cpop) begin
            crd_q <= (crd_q == CAW'(CMD_DEPTH - 1)) ? '0 : crd_q + 1'b1;
         end
         ccnt_q <= ccnt_q + (CAW+1)'(cpush) - (CAW+1)'(cpop);
      end
   end

   always_ff @(posedge pclk) begin
      if (cpush) begin
         cmem[cwr_q] <= pwdata;
      end
   end

   // command head register toward the sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_valid <= 1'b0;
         cmd_word <= 32'h0000_0000;
      end else if (cpop) begin
         cmd_valid <= 1'b1;
         cmd_word <= cmem[crd_q];
      end else if (cmd_ready) begin
         cmd_valid <= 1'b0;
      end
   end

   // checksum over executed commands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_q <= sfcr_pkg::CHECKSUM_RESET;
      end else if (exec_valid) begin
         crc_q <= crc8_word(crc_q, exec_word);
      end
   end

   // sequencer run state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_state <= sfcr_pkg::SEQ_IDLE;
         sleep_enter <= 1'b0;
      end else begin
         sleep_enter <= 1'b0;
         case (seq_state)
            sfcr_pkg::SEQ_IDLE: begin
               if (seq_en_q) begin
                  seq_state <= sfcr_pkg::SEQ_RUN;
               end
            end
            sfcr_pkg::SEQ_RUN: begin
               if (!seq_en_q) begin
                  seq_state <= sfcr_pkg::SEQ_IDLE;
               end else if (seq_end && sleep_req_q) begin
                  seq_state <= sfcr_pkg::SEQ_ASLEEP;
                  sleep_enter <= 1'b1;
               end else if (seq_fetch && stop_uf_q && !cmd_valid) begin
                  seq_state <= sfcr_pkg::SEQ_HALTED;
               end
            end
            sfcr_pkg::SEQ_HALTED, sfcr_pkg::SEQ_ASLEEP: begin
               if (!seq_en_q) begin
                  seq_state <= sfcr_pkg::SEQ_IDLE;
               end
            end
            default: seq_state <= sfcr_pkg::SEQ_IDLE;
         endcase
      end
   end

   // two-entry buffer fill level
   always_comb begin
      bcnt_d = bcnt_q;
      if (!queue_en_q) begin
         bcnt_d = 2'h0;
      end else if (bpush && !bpop) begin
         bcnt_d = bcnt_q + 2'h1;
      end else if (!bpush && bpop) begin
         bcnt_d = bcnt_q - 2'h1;
      end
   end

   // two-entry buffer in the result path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_q <= 2'h0;
         res_ready <= 1'b0;
         buf_q[0] <= 32'h0000_0000;
         buf_q[1] <= 32'h0000_0000;
      end else begin
         bcnt_q <= bcnt_d;
         res_ready <= queue_en_q & (bcnt_d != 2'h2);
         if (bpop) begin
            buf_q[0] <= (bpush && bcnt_q == 2'h1) ? res_word : buf_q[1];
            if (bpush && bcnt_q == 2'h2) begin
               buf_q[1] <= res_word;
            end
         end else if (bpush) begin
            if (bcnt_q == 2'h0) begin
               buf_q[0] <= res_word;
            end else begin
               buf_q[1] <= res_word;
            end
         end
      end
   end

   // result queue pointers, held empty while disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rwr_q <= '0;
         rrd_q <= '0;
         rcnt_q <= '0;
      end else if (!queue_en_q) begin
         rwr_q <= '0;
         rrd_q <= '0;
         rcnt_q <= '0;
      end else begin
         if (bpop) begin
            rwr_q <= (rwr_q == RAW'(RES_DEPTH - 1)) ? '0 : rwr_q + 1'b1;
         end
         if (rpop) begin
            rrd_q <= (rrd_q == RAW'(RES_DEPTH - 1)) ? '0 : rrd_q + 1'b1;
         end
         rcnt_q <= rcnt_q + (RAW+1)'(bpop) - (RAW+1)'(rpop);
      end
   end

   always_ff @(posedge pclk) begin
      if (bpop) begin
         rmem[rwr_q] <= buf_q[0];
      end
   end
endmodule : sfcr_top
`default_nettype wire

// ===== dv/sfcr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sfcr_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_word,
   input wire logic cmd_ready,
   input wire logic seq_end,
   input wire logic [29:0] timeout_value,
   input wire sfcr_pkg::sfcr_state_e seq_state,
   input wire logic sleep_enter,
   input wire sfcr_pkg::sfcr_desc_s seq0_desc,
   input wire sfcr_pkg::sfcr_memcfg_s mem_cfg
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // decoded apb phases
   logic rd_setup;
   logic acc_wr;
   assign rd_setup = psel && !penable && !pwrite;
   assign acc_wr = psel && penable && pready && pwrite;
   property p_rdy;
      psel && !penable |=> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy_one;
      pready |=> !pready;
   endproperty
   a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
   property p_cksum_hi;
      rd_setup && paddr == sfcr_pkg::OFS_CHECKSUM |=> prdata[31:8] == 24'h0;
   endproperty
   a_cksum_hi: assert property (p_cksum_hi) else $error("checksum high");
   property p_tmo;
      rd_setup && paddr == sfcr_pkg::OFS_TIMEOUT
         |=> prdata == {2'b00, $past(timeout_value)};
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout read wrong");
   property p_desc_rd;
      rd_setup && paddr == sfcr_pkg::OFS_SEQ0_DESC
         |=> prdata == {5'h00, seq0_desc.length, 5'h00, seq0_desc.origin};
   endproperty
   a_desc_rd: assert property (p_desc_rd) else $error("desc read");
   property p_cfg_wr;
      acc_wr && paddr == sfcr_pkg::OFS_MEM_CFG
         |=> mem_cfg == $past(pwdata[11:0]);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("mem cfg write");
   property p_sleep;
      sleep_enter |-> $past(seq_end) && seq_state == sfcr_pkg::SEQ_ASLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep without end");
   property p_sleep_one;
      sleep_enter |=> !sleep_enter;
   endproperty
   a_sleep_one: assert property (p_sleep_one) else $error("sleep pulse");
   property p_cmd_hold;
      cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("cmd lost");
   property p_bad;
      pslverr && !pwrite |-> pready && prdata == 32'h0;
   endproperty
   a_bad: assert property (p_bad) else $error("bad read data");
endmodule : sfcr_asserts
bind sfcr_top sfcr_asserts sfcr_asserts_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
   .seq_end(seq_end), .timeout_value(timeout_value),
   .seq_state(seq_state), .sleep_enter(sleep_enter),
   .seq0_desc(seq0_desc), .mem_cfg(mem_cfg));
`default_nettype wire

// ===== dv/test_sequencer_fifo_control_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module test_sequencer_fifo_control_regs;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, res_word = 0, cmd_word, exec_word = 0;
   logic [31:0] rd;
   logic pready, pslverr, res_valid = 0, res_ready, cmd_valid, cmd_ready = 0;
   logic seq_fetch = 0, exec_valid = 0, seq_end = 0, sleep_enter;
   logic [29:0] timeout_value = 30'h2ABCDEF1;
   sfcr_pkg::sfcr_state_e seq_state;
   sfcr_pkg::sfcr_desc_s seq0_desc, seq2_desc;
   sfcr_pkg::sfcr_memcfg_s mem_cfg;
   sfcr_pkg::sfcr_store_s cmd_store, stored = '0;
   int failures = 0, compares = 0, slept = 0;
   always #4 pclk = ~pclk;
   // catch one-cycle store and sleep pulses
   always @(posedge pclk) begin
      if (cmd_store.we === 1'b1) stored <= cmd_store;
      if (sleep_enter === 1'b1) slept <= slept + 1;
   end
   sfcr_top #(.CMD_DEPTH(4), .RES_DEPTH(4)) sfcr_top_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .res_valid(res_valid), .res_word(res_word),
      .res_ready(res_ready), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_ready(cmd_ready), .seq_fetch(seq_fetch), .exec_valid(exec_valid),
      .exec_word(exec_word), .seq_end(seq_end),
      .timeout_value(timeout_value), .seq_state(seq_state),
      .sleep_enter(sleep_enter), .seq0_desc(seq0_desc),
      .seq2_desc(seq2_desc), .mem_cfg(mem_cfg), .cmd_store(cmd_store));
   // one apb transfer, held until ready
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rchk
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? sfcr_pkg::CRC_POLY : 8'h00);
      return c;
   endfunction : crc8
   task automatic t_reset;
      rchk(sfcr_pkg::OFS_CHECKSUM, 32'h1);
      rchk(sfcr_pkg::OFS_TIMEOUT, {2'b00, timeout_value});
      @(posedge pclk);
      timeout_value <= 30'h15A5A5A5;
      rchk(sfcr_pkg::OFS_TIMEOUT, 32'h15A5A5A5);
      rchk(sfcr_pkg::OFS_SLEEP_KEY, 32'h0);
      rchk(sfcr_pkg::OFS_SLEEP_REQ, 32'h0);
      rchk(sfcr_pkg::OFS_STORE_PTR, 32'h0);
      rchk(sfcr_pkg::OFS_MEM_CFG, 32'h410);
      xfer(1'b0, 16'h2004, 32'h0);
      `CHK({err, rd}, 33'h100000000)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_fields;
      xfer(1'b1, sfcr_pkg::OFS_SEQ0_DESC, 32'hFFFFFFFF);
      rchk(sfcr_pkg::OFS_SEQ0_DESC, 32'h07FF07FF);
      `CHK(seq0_desc, 22'h3FFFFF)
      xfer(1'b1, sfcr_pkg::OFS_SEQ2_DESC, 32'h0ABC0123);
      rchk(sfcr_pkg::OFS_SEQ2_DESC, 32'h02BC0123);
      `CHK(seq2_desc, {11'h2BC, 11'h123})
      xfer(1'b1, sfcr_pkg::OFS_STORE_PTR, 32'hFFFFFFFF);
      rchk(sfcr_pkg::OFS_STORE_PTR, 32'h7FF);
      xfer(1'b1, sfcr_pkg::OFS_MEM_CFG, 32'hFFFFFFFF);
      rchk(sfcr_pkg::OFS_MEM_CFG, 32'hFFF);
      xfer(1'b1, sfcr_pkg::OFS_CHECKSUM, 32'hFF);
      rchk(sfcr_pkg::OFS_CHECKSUM, 32'h1);
      $display("t_fields done");
   endtask : t_fields
   task automatic t_crc;
      logic [7:0] e;
      e = sfcr_pkg::CHECKSUM_RESET;
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         exec_valid <= 1'b1;
         exec_word <= 32'h12345678 * (i + 1);
         e = crc8(e, 32'h12345678 * (i + 1));
         @(posedge pclk);
         exec_valid <= 1'b0;
      end
      rchk(sfcr_pkg::OFS_CHECKSUM, {24'h0, e});
      $display("t_crc done");
   endtask : t_crc
   task automatic push(input logic [31:0] w);
      @(posedge pclk);
      res_valid <= 1'b1;
      res_word <= w;
      do @(posedge pclk); while (res_ready !== 1'b1);
      res_valid <= 1'b0;
   endtask : push
   task automatic t_result;
      xfer(1'b1, sfcr_pkg::OFS_MEM_CFG, 32'h410);
      xfer(1'b1, sfcr_pkg::OFS_QUEUE_CTRL, 32'h800);
      rchk(sfcr_pkg::OFS_RESULT_PORT, 32'h0);
      for (int i = 0; i < 6; i++) push(32'hA5000000 + i);
      repeat (3) @(posedge pclk);
      `CHK(res_ready, 1'b0)
      for (int i = 0; i < 6; i++)
         rchk(sfcr_pkg::OFS_RESULT_PORT, 32'hA5000000 + i);
      rchk(sfcr_pkg::OFS_RESULT_PORT, 32'h0);
      push(32'h5A5A5A5A);
      repeat (3) @(posedge pclk);
      xfer(1'b1, sfcr_pkg::OFS_QUEUE_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(res_ready, 1'b0)
      xfer(1'b1, sfcr_pkg::OFS_QUEUE_CTRL, 32'h800);
      rchk(sfcr_pkg::OFS_RESULT_PORT, 32'h0);
      $display("t_result done");
   endtask : t_result
   task automatic t_cmd;
      // four queue slots plus the head register; the sixth is dropped
      for (int i = 0; i < 6; i++)
         xfer(1'b1, sfcr_pkg::OFS_CMD_PORT, 32'hC0DE0000 + i);
      cmd_ready <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         do @(posedge pclk); while (cmd_valid !== 1'b1);
         `CHK(cmd_word, 32'hC0DE0000 + i)
      end
      cmd_ready <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(cmd_valid, 1'b0)
      $display("t_cmd done");
   endtask : t_cmd
   task automatic t_store;
      xfer(1'b1, sfcr_pkg::OFS_MEM_CFG, 32'h4CB);
      @(posedge pclk);
      `CHK(mem_cfg, 12'h4CB)
      xfer(1'b1, sfcr_pkg::OFS_STORE_PTR, 32'h7FF);
      xfer(1'b1, sfcr_pkg::OFS_CMD_PORT, 32'hBEEF0001);
      repeat (2) @(posedge pclk);
      `CHK(stored, {1'b1, 11'h7FF, 32'hBEEF0001})
      `CHK(cmd_valid, 1'b0)
      rchk(sfcr_pkg::OFS_STORE_PTR, 32'h0);
      xfer(1'b1, sfcr_pkg::OFS_MEM_CFG, 32'h410);
      $display("t_store done");
   endtask : t_store
   task automatic t_sleep;
      xfer(1'b1, sfcr_pkg::OFS_SLEEP_REQ, 32'h1);
      rchk(sfcr_pkg::OFS_SLEEP_REQ, 32'h0);
      xfer(1'b1, sfcr_pkg::OFS_SLEEP_KEY, 32'hFFFA47E5);
      rchk(sfcr_pkg::OFS_SLEEP_KEY, 32'hA47E5);
      xfer(1'b1, sfcr_pkg::OFS_SLEEP_REQ, 32'hFFFFFFFF);
      rchk(sfcr_pkg::OFS_SLEEP_REQ, 32'h1);
      xfer(1'b1, sfcr_pkg::OFS_SLEEP_KEY, 32'hA47E4);
      xfer(1'b1, sfcr_pkg::OFS_SLEEP_REQ, 32'h0);
      rchk(sfcr_pkg::OFS_SLEEP_REQ, 32'h1);
      xfer(1'b1, sfcr_pkg::OFS_SEQ_CTRL, 32'h3);
      @(posedge pclk);
      seq_fetch <= 1'b1;
      @(posedge pclk);
      seq_fetch <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(seq_state, sfcr_pkg::SEQ_HALTED)
      xfer(1'b1, sfcr_pkg::OFS_SEQ_CTRL, 32'h0);
      repeat (2) @(posedge pclk);
      `CHK(seq_state, sfcr_pkg::SEQ_IDLE)
      xfer(1'b1, sfcr_pkg::OFS_SEQ_CTRL, 32'h1);
      @(posedge pclk);
      seq_fetch <= 1'b1;
      @(posedge pclk);
      seq_fetch <= 1'b0;
      seq_end <= 1'b1;
      @(posedge pclk);
      seq_end <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(seq_state, sfcr_pkg::SEQ_ASLEEP)
      `CHK(slept, 1)
      $display("t_sleep done");
   endtask : t_sleep
   task print_verdict;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_fields;
      t_crc;
      t_result;
      t_cmd;
      t_store;
      t_sleep;
      print_verdict;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      print_verdict;
   end
endmodule : test_sequencer_fifo_control_regs
`default_nettype wire
